// ### hw/mie_alu.sv
// Purpose: add, add-with-carry and AND with their flag results
// Assumes: purely combinational, the caller decides which flags to keep
// Notes: wrap is the carry into bit 7 against the carry out of bit 7
`timescale 1ns/10ps
module mie_alu (
  input mie_pkg::mie_alu_e kind,
  input logic [7:0] a,
  input logic [7:0] b,
  input logic cin,
  output mie_pkg::mie_alu_s out
);

  logic ci;
  logic [4:0] lo;
  logic [7:0] mid;
  logic [8:0] full;

  // ==========================================================
  // Adders, split so the nibble and bit-7 carries come out cheaply
  always_comb
  begin
    ci = (kind == mie_pkg::ALU_ADC) ? cin : 1'b0;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    out.nibble = lo[4];
    out.carry = full[8];
    out.wrap = mid[7] ^ full[8];
    out.res = (kind == mie_pkg::ALU_AND) ? (a & b) : full[7:0];
    out.zero = (out.res == mie_pkg::MIE_BYTE_ZERO);
  end

endmodule

// ### hw/mie_core.sv
// Purpose: instruction execution core, one cycle per instruction, two for jumps, taken skips, PCL writes and table reads
// Assumes: program and data memory answer a read in the same cycle
// Notes: the watchdog counter itself lives outside; it sees a clear pulse
`timescale 1ns/10ps
module mie_core (
  input logic clk_sys,
  input logic reset,
  output logic [mie_pkg::MIE_PC_W-1:0] prog_addr,
  input logic [mie_pkg::MIE_WORD_W-1:0] prog_data,
  output logic [mie_pkg::MIE_MADDR_W-1:0] dmem_addr,
  input logic [mie_pkg::MIE_DATA_W-1:0] dmem_rdata,
  output logic [mie_pkg::MIE_DATA_W-1:0] dmem_wdata,
  output logic dmem_we,
  input logic [mie_pkg::MIE_DATA_W-1:0] table_pointer,
  input logic irq_pending,
  input logic watchdog_timeout,
  input logic wake_pin,
  output logic watchdog_counter_clear,
  output logic clock_stop,
  output logic master_irq_enable,
  output logic [mie_pkg::MIE_DATA_W-1:0] acc,
  output logic [mie_pkg::MIE_DATA_W-1:0] lookup_high_byte,
  output mie_pkg::mie_flags_s status
);

  // ==========================================================
  // State
  mie_pkg::mie_state_e state_q;
  mie_pkg::mie_pre_e pre_q;
  mie_pkg::mie_pre_e pre_d;
  mie_pkg::mie_flags_s flags_q;
  logic [mie_pkg::MIE_PC_W-1:0] pc_q;
  logic [mie_pkg::MIE_PC_W-1:0] tbl_addr_q;
  logic [mie_pkg::MIE_MADDR_W-1:0] tbl_dst_q;
  logic [7:0] acc_q;
  logic [7:0] lookup_q;
  logic irq_en_q;
  logic wdt_clr_q;
  logic wake_s1_q;
  logic wake_s2_q;
  logic wake_s3_q;

  // ==========================================================
  // Decode
  mie_pkg::mie_instr_s instr;
  mie_pkg::mie_alu_s alu_out;
  mie_pkg::mie_alu_e alu_kind;
  logic [mie_pkg::MIE_MADDR_W-1:0] m;
  logic [2:0] bit_idx;
  logic [7:0] imm;
  logic [7:0] mem_rd;
  logic [7:0] mask;
  logic [7:0] alu_b;
  logic [7:0] res;
  logic [mie_pkg::MIE_PC_W-1:0] tgt;
  logic [mie_pkg::MIE_PC_W-1:0] stack_top;
  logic [mie_pkg::MIE_PC_W-1:0] push_data;
  logic to_mem;
  logic to_acc;
  logic arith;
  logic zonly;
  logic skip;
  logic jump;
  logic push;
  logic pop;
  logic table_go;
  logic halt;
  logic wdt_kick;
  logic irq_ret;
  logic irq_take;
  logic ex;
  logic pcl_hit;
  logic wake_seen;

  // Immediate operand forms of the arithmetic and logic group
  function automatic logic uses_imm(input mie_pkg::mie_op_e op);
    uses_imm = (op == mie_pkg::OP_ADD_IMM) || (op == mie_pkg::OP_AND_IMM);
  endfunction

  assign instr = prog_data;
  assign m = instr.arg[mie_pkg::MIE_MADDR_HI:0];
  assign bit_idx = instr.arg[mie_pkg::MIE_BIT_HI:mie_pkg::MIE_BIT_LO];
  assign imm = instr.arg[mie_pkg::MIE_IMM_HI:0];
  assign mask = mie_pkg::MIE_BIT_ONE << bit_idx;
  // The low program counter byte is visible as a data location
  assign mem_rd = (m == mie_pkg::MIE_PCL_ADDR) ? pc_q[7:0] : dmem_rdata;
  assign alu_b = uses_imm(instr.op) ? imm : mem_rd;

  // Interrupts are taken only at an instruction boundary
  assign irq_take = (state_q == mie_pkg::ST_EXEC) && irq_pending && irq_en_q;
  assign ex = (state_q == mie_pkg::ST_EXEC) && !irq_take;
  assign pcl_hit = to_mem && (m == mie_pkg::MIE_PCL_ADDR);

  // ALU selection
  always_comb
  begin
    case (instr.op)
      mie_pkg::OP_ADC_MEM, mie_pkg::OP_ADC_INTO_MEM: alu_kind = mie_pkg::ALU_ADC;
      mie_pkg::OP_AND_MEM, mie_pkg::OP_AND_INTO_MEM,
      mie_pkg::OP_AND_IMM: alu_kind = mie_pkg::ALU_AND;
      default: alu_kind = mie_pkg::ALU_ADD;
    endcase
  end

  mie_alu u_alu (
    .kind(alu_kind),
    .a(acc_q),
    .b(alu_b),
    .cin(flags_q.carry_flag),
    .out(alu_out)
  );

  // ==========================================================
  // Per-instruction effects; the write-back is done by the processes below
  always_comb
  begin
    res = mie_pkg::MIE_BYTE_ZERO;
    to_mem = 1'b0;
    to_acc = 1'b0;
    arith = 1'b0;
    zonly = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    tgt = instr.arg;
    push = 1'b0;
    pop = 1'b0;
    table_go = 1'b0;
    halt = 1'b0;
    wdt_kick = 1'b0;
    irq_ret = 1'b0;
    pre_d = mie_pkg::PRE_NONE;
    case (instr.op)
      mie_pkg::OP_LOAD_ACC, mie_pkg::OP_LOAD_IMM:
      begin
        res = (instr.op == mie_pkg::OP_LOAD_IMM) ? imm : mem_rd;
        to_acc = 1'b1;
      end
      mie_pkg::OP_STORE_ACC:
      begin
        res = acc_q;
        to_mem = 1'b1;
      end
      mie_pkg::OP_BIT_CLR:
      begin
        res = mem_rd & ~mask;
        to_mem = 1'b1;
      end
      mie_pkg::OP_BIT_SET:
      begin
        res = mem_rd | mask;
        to_mem = 1'b1;
      end
      mie_pkg::OP_BYTE_CLR:
      begin
        res = mie_pkg::MIE_BYTE_ZERO;
        to_mem = 1'b1;
      end
      mie_pkg::OP_BYTE_SET:
      begin
        res = mie_pkg::MIE_BYTE_ONES;
        to_mem = 1'b1;
      end
      mie_pkg::OP_JUMP:
        jump = 1'b1;
      mie_pkg::OP_CALL:
      begin
        jump = 1'b1;
        push = 1'b1;
      end
      mie_pkg::OP_RETURN, mie_pkg::OP_RETURN_IMM, mie_pkg::OP_IRQ_RETURN:
      begin
        jump = 1'b1;
        pop = 1'b1;
        tgt = stack_top;
        res = imm;
        to_acc = (instr.op == mie_pkg::OP_RETURN_IMM);
        irq_ret = (instr.op == mie_pkg::OP_IRQ_RETURN);
      end
      mie_pkg::OP_SKIP_ZERO:
        skip = (mem_rd == mie_pkg::MIE_BYTE_ZERO);
      mie_pkg::OP_SKIP_ZERO_MOVE:
      begin
        res = mem_rd;
        to_acc = 1'b1;
        skip = (mem_rd == mie_pkg::MIE_BYTE_ZERO);
      end
      mie_pkg::OP_SKIP_BIT_ZERO:
        skip = !mem_rd[bit_idx];
      mie_pkg::OP_SKIP_BIT_NONZERO:
        skip = mem_rd[bit_idx];
      mie_pkg::OP_INC_SKIP, mie_pkg::OP_INC_SKIP_ACC:
      begin
        res = mem_rd + mie_pkg::MIE_BYTE_STEP;
        to_mem = (instr.op == mie_pkg::OP_INC_SKIP);
        to_acc = (instr.op == mie_pkg::OP_INC_SKIP_ACC);
        skip = (res == mie_pkg::MIE_BYTE_ZERO);
      end
      mie_pkg::OP_DEC_SKIP, mie_pkg::OP_DEC_SKIP_ACC:
      begin
        res = mem_rd - mie_pkg::MIE_BYTE_STEP;
        to_mem = (instr.op == mie_pkg::OP_DEC_SKIP);
        to_acc = (instr.op == mie_pkg::OP_DEC_SKIP_ACC);
        skip = (res == mie_pkg::MIE_BYTE_ZERO);
      end
      mie_pkg::OP_TABLE_CUR, mie_pkg::OP_TABLE_LAST:
        table_go = 1'b1;
      mie_pkg::OP_WDT_CLEAR:
        wdt_kick = 1'b1;
      mie_pkg::OP_WDT_PRE_A:
      begin
        // Only the other half completes the pair; a repeat just waits
        wdt_kick = (pre_q == mie_pkg::PRE_B);
        pre_d = wdt_kick ? mie_pkg::PRE_NONE : mie_pkg::PRE_A;
      end
      mie_pkg::OP_WDT_PRE_B:
      begin
        wdt_kick = (pre_q == mie_pkg::PRE_A);
        pre_d = wdt_kick ? mie_pkg::PRE_NONE : mie_pkg::PRE_B;
      end
      mie_pkg::OP_NIBBLE_SWAP, mie_pkg::OP_NIBBLE_SWAP_ACC:
      begin
        res = {mem_rd[mie_pkg::MIE_NIB_HI:0],
               mem_rd[mie_pkg::MIE_HALF_HI:mie_pkg::MIE_HALF_LO]};
        to_mem = (instr.op == mie_pkg::OP_NIBBLE_SWAP);
        to_acc = (instr.op == mie_pkg::OP_NIBBLE_SWAP_ACC);
      end
      mie_pkg::OP_HALT:
        halt = 1'b1;
      mie_pkg::OP_ADD_MEM, mie_pkg::OP_ADD_IMM, mie_pkg::OP_ADC_MEM:
      begin
        res = alu_out.res;
        to_acc = 1'b1;
        arith = 1'b1;
      end
      mie_pkg::OP_ADD_INTO_MEM, mie_pkg::OP_ADC_INTO_MEM:
      begin
        res = alu_out.res;
        to_mem = 1'b1;
        arith = 1'b1;
      end
      mie_pkg::OP_AND_MEM, mie_pkg::OP_AND_IMM, mie_pkg::OP_AND_INTO_MEM:
      begin
        res = alu_out.res;
        to_mem = (instr.op == mie_pkg::OP_AND_INTO_MEM);
        to_acc = !to_mem;
        zonly = 1'b1;
      end
      default:
        res = mie_pkg::MIE_BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // Stack: a call saves the next address, an interrupt the unexecuted one
  assign push_data = irq_take ? pc_q : pc_q + mie_pkg::MIE_PC_STEP;

  mie_stack u_stack (
    .clk_sys(clk_sys),
    .reset(reset),
    .push(irq_take || (ex && push)),
    .pop(ex && pop),
    .push_data(push_data),
    .top(stack_top)
  );

  // ==========================================================
  // Sequencing and program counter
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= mie_pkg::ST_EXEC;
      pc_q <= mie_pkg::MIE_RESET_VECTOR;
    end
    else
    begin
      case (state_q)
        mie_pkg::ST_EXEC:
        begin
          if (irq_take)
          begin
            pc_q <= mie_pkg::MIE_IRQ_VECTOR;
            state_q <= mie_pkg::ST_DUMMY;
          end
          else if (halt)
          begin
            pc_q <= pc_q + mie_pkg::MIE_PC_STEP;
            state_q <= mie_pkg::ST_SLEEP;
          end
          else if (table_go)
          begin
            pc_q <= pc_q + mie_pkg::MIE_PC_STEP;
            state_q <= mie_pkg::ST_TABLE;
          end
          else if (jump)
          begin
            pc_q <= tgt;
            state_q <= mie_pkg::ST_DUMMY;
          end
          else if (pcl_hit)
          begin
            pc_q <= {pc_q[mie_pkg::MIE_PC_W-1:mie_pkg::MIE_DATA_W], res};
            state_q <= mie_pkg::ST_DUMMY;
          end
          else if (skip)
          begin
            pc_q <= pc_q + mie_pkg::MIE_SKIP_STEP;
            state_q <= mie_pkg::ST_DUMMY;
          end
          else
            pc_q <= pc_q + mie_pkg::MIE_PC_STEP;
        end
        mie_pkg::ST_DUMMY, mie_pkg::ST_TABLE:
          state_q <= mie_pkg::ST_EXEC;
        mie_pkg::ST_SLEEP:
          if (wake_seen)
            state_q <= mie_pkg::ST_EXEC;
        default:
          state_q <= mie_pkg::ST_EXEC;
      endcase
    end
  end

  // Table source address and destination captured in the first cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tbl_addr_q <= mie_pkg::MIE_RESET_VECTOR;
      tbl_dst_q <= '0;
    end
    else if (ex && table_go)
    begin
      tbl_addr_q <= {(instr.op == mie_pkg::OP_TABLE_LAST) ? mie_pkg::MIE_LAST_PAGE
                     : pc_q[mie_pkg::MIE_PC_W-1:mie_pkg::MIE_DATA_W],
                     table_pointer};
      tbl_dst_q <= m;
    end
  end

  // ==========================================================
  // Accumulator and lookup byte
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      acc_q <= mie_pkg::MIE_BYTE_ZERO;
    else if (ex && to_acc)
      acc_q <= res;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      lookup_q <= mie_pkg::MIE_BYTE_ZERO;
    else if (state_q == mie_pkg::ST_TABLE)
      lookup_q <= prog_data[mie_pkg::MIE_WORD_W-1:mie_pkg::MIE_DATA_W];
  end

  // ==========================================================
  // Status flags; a timeout in the clearing cycle still sets the flag
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      flags_q <= '0;
    else
    begin
      if (ex && arith)
      begin
        flags_q.carry_flag <= alu_out.carry;
        flags_q.nibble_carry_flag <= alu_out.nibble;
        flags_q.signed_wrap_flag <= alu_out.wrap;
        flags_q.zero_flag <= alu_out.zero;
      end
      else if (ex && zonly)
        flags_q.zero_flag <= alu_out.zero;
      if (ex && halt)
        flags_q.sleep_entered_flag <= 1'b1;
      else if (ex && wdt_kick)
        flags_q.sleep_entered_flag <= 1'b0;
      if (watchdog_timeout)
        flags_q.watchdog_expired_flag <= 1'b1;
      else if (ex && (halt || wdt_kick))
        flags_q.watchdog_expired_flag <= 1'b0;
    end
  end

  // Pre-clear tracker: any other executed instruction breaks the pair
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pre_q <= mie_pkg::PRE_NONE;
    else if (ex)
      pre_q <= pre_d;
  end

  // Watchdog counter and prescaler clear, one cycle pulse
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wdt_clr_q <= 1'b0;
    else
      wdt_clr_q <= ex && (wdt_kick || halt);
  end

  // Master enable: dropped on entry, restored by interrupt return
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irq_en_q <= 1'b0;
    else if (irq_take)
      irq_en_q <= 1'b0;
    else if (ex && irq_ret)
      irq_en_q <= 1'b1;
  end

  // ==========================================================
  // Wake pin comes from outside; three stages, last two must agree
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end
    else
    begin
      wake_s1_q <= wake_pin;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  assign wake_seen = wake_s2_q && wake_s3_q;

  // ==========================================================
  // Outputs; memory strobes are combinational since reads are same-cycle
  assign prog_addr = (state_q == mie_pkg::ST_TABLE) ? tbl_addr_q : pc_q;
  assign dmem_addr = (state_q == mie_pkg::ST_TABLE) ? tbl_dst_q : m;
  assign dmem_wdata = (state_q == mie_pkg::ST_TABLE)
                      ? prog_data[mie_pkg::MIE_DATA_W-1:0] : res;
  assign dmem_we = (state_q == mie_pkg::ST_TABLE)
                   || (ex && to_mem && !pcl_hit);
  assign clock_stop = (state_q == mie_pkg::ST_SLEEP);
  assign watchdog_counter_clear = wdt_clr_q;
  assign master_irq_enable = irq_en_q;
  assign acc = acc_q;
  assign lookup_high_byte = lookup_q;
  assign status = flags_q;

endmodule

// ### hw/mie_pkg.sv
// Purpose: shared constants and types of the instruction execution core
// Assumes: one 16-bit program word per instruction, 8-bit data path
// Notes: opcode values follow the order of mie_op_e, starting at zero
package mie_pkg;

  // ==========================================================
  // Widths and depths
  localparam int MIE_PC_W = 10;
  localparam int MIE_DATA_W = 8;
  localparam int MIE_MADDR_W = 7;
  localparam int MIE_WORD_W = 16;
  localparam int MIE_OP_W = 6;
  localparam int MIE_ARG_W = 10;
  localparam int MIE_STACK_DEPTH = 4;
  localparam int MIE_STACK_IDX_W = 2;

  // ==========================================================
  // Operand field positions inside the 10-bit argument
  localparam int MIE_BIT_HI = 9;
  localparam int MIE_BIT_LO = 7;
  localparam int MIE_MADDR_HI = 6;
  localparam int MIE_IMM_HI = 7;
  localparam int MIE_HALF_HI = 7;
  localparam int MIE_HALF_LO = 4;
  localparam int MIE_NIB_HI = 3;

  // ==========================================================
  // Addresses, vectors and constant values
  localparam logic [MIE_MADDR_W-1:0] MIE_PCL_ADDR = 7'h06;
  localparam logic [MIE_PC_W-1:0] MIE_RESET_VECTOR = 10'h000;
  localparam logic [MIE_PC_W-1:0] MIE_IRQ_VECTOR = 10'h004;
  localparam logic [MIE_PC_W-1:0] MIE_PC_STEP = 10'h001;
  localparam logic [MIE_PC_W-1:0] MIE_SKIP_STEP = 10'h002;
  localparam logic [1:0] MIE_LAST_PAGE = 2'h3;
  localparam logic [7:0] MIE_BYTE_ZERO = 8'h00;
  localparam logic [7:0] MIE_BYTE_ONES = 8'hff;
  localparam logic [7:0] MIE_BIT_ONE = 8'h01;
  localparam logic [7:0] MIE_BYTE_STEP = 8'h01;

  // ==========================================================
  // Operations, in opcode order
  typedef enum logic [MIE_OP_W-1:0] {
    OP_NOP, OP_LOAD_ACC, OP_STORE_ACC, OP_LOAD_IMM,
    OP_BIT_CLR, OP_BIT_SET, OP_BYTE_CLR, OP_BYTE_SET,
    OP_JUMP, OP_CALL, OP_RETURN, OP_RETURN_IMM, OP_IRQ_RETURN,
    OP_SKIP_ZERO, OP_SKIP_ZERO_MOVE, OP_SKIP_BIT_ZERO, OP_SKIP_BIT_NONZERO,
    OP_INC_SKIP, OP_DEC_SKIP, OP_INC_SKIP_ACC, OP_DEC_SKIP_ACC,
    OP_TABLE_CUR, OP_TABLE_LAST,
    OP_WDT_CLEAR, OP_WDT_PRE_A, OP_WDT_PRE_B,
    OP_NIBBLE_SWAP, OP_NIBBLE_SWAP_ACC, OP_HALT,
    OP_ADD_MEM, OP_ADD_INTO_MEM, OP_ADD_IMM,
    OP_ADC_MEM, OP_ADC_INTO_MEM,
    OP_AND_MEM, OP_AND_INTO_MEM, OP_AND_IMM
  } mie_op_e;

  typedef enum logic [1:0] {ST_EXEC, ST_DUMMY, ST_TABLE, ST_SLEEP} mie_state_e;
  typedef enum logic [1:0] {PRE_NONE, PRE_A, PRE_B} mie_pre_e;
  typedef enum logic [1:0] {ALU_ADD, ALU_ADC, ALU_AND} mie_alu_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    mie_op_e op;
    logic [MIE_ARG_W-1:0] arg;
  } mie_instr_s;

  typedef struct packed {
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
  } mie_flags_s;

  typedef struct packed {
    logic [MIE_DATA_W-1:0] res;
    logic carry;
    logic nibble;
    logic wrap;
    logic zero;
  } mie_alu_s;

endpackage

// ### hw/mie_stack.sv
// Purpose: return address stack of the core
// Assumes: push and pop never in the same cycle
// Notes: overflow wraps round and overwrites the oldest entry
`timescale 1ns/10ps
module mie_stack (
  input logic clk_sys,
  input logic reset,
  input logic push,
  input logic pop,
  input logic [mie_pkg::MIE_PC_W-1:0] push_data,
  output logic [mie_pkg::MIE_PC_W-1:0] top
);

  logic [mie_pkg::MIE_PC_W-1:0] mem_q [mie_pkg::MIE_STACK_DEPTH];
  logic [mie_pkg::MIE_STACK_IDX_W-1:0] ptr_q;
  logic [mie_pkg::MIE_STACK_IDX_W-1:0] top_idx;

  assign top_idx = ptr_q - 2'h1;
  assign top = mem_q[top_idx];

  // ==========================================================
  // Pointer; a wrapped stack is a software fault, not checked here
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ptr_q <= '0;
    else if (push)
      ptr_q <= ptr_q + 2'h1;
    else if (pop)
      ptr_q <= top_idx;
  end

  // Storage has no reset, as in the real array
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[ptr_q] <= push_data;
  end

endmodule

// ### sim/mie_core_chk.sv
// Purpose: port checks of the execution core
// Assumes: one clock, synchronous active-high reset
// Notes: no state is visible, so checks centre on sleep and watchdog
`timescale 1ns/10ps
module mie_core_chk (
  input logic clk_sys,
  input logic reset,
  input logic dmem_we,
  input logic wake_pin,
  input logic watchdog_timeout,
  input logic watchdog_counter_clear,
  input logic clock_stop,
  input logic [mie_pkg::MIE_DATA_W-1:0] acc,
  input logic [mie_pkg::MIE_PC_W-1:0] prog_addr,
  input mie_pkg::mie_flags_s status
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Sleep entry, stay and exit
  chk_sleep_pulse: assert property ($rose(clock_stop) |-> watchdog_counter_clear)
    else $error("no counter clear at sleep entry");
  chk_sleep_flags: assert property ($rose(clock_stop) && !$past(watchdog_timeout)
    |-> status.sleep_entered_flag && !status.watchdog_expired_flag)
    else $error("wrong flags at sleep entry");
  // Wake goes through a synchroniser, so a quiet pin must hold sleep
  chk_sleep_hold: assert property (clock_stop && !wake_pin && !$past(wake_pin)
    && !$past(wake_pin, 2) |=> clock_stop)
    else $error("left sleep without wake");
  chk_sleep_nowr: assert property (clock_stop |-> !dmem_we)
    else $error("memory written in sleep");
  chk_sleep_keep: assert property (clock_stop && $past(clock_stop)
    |-> $stable(acc) && $stable(prog_addr))
    else $error("state moved in sleep");
  // The exit decision reads pin samples taken three and four edges earlier
  chk_wake_cause: assert property ($fell(clock_stop) && !$past(reset)
    |-> $past(wake_pin, 3) && $past(wake_pin, 4))
    else $error("woke without wake pin");
  // ==========================================================
  // Watchdog flags
  chk_expired_fall: assert property ($fell(status.watchdog_expired_flag)
    |-> watchdog_counter_clear)
    else $error("expired flag fell without a clear");
  chk_expired_set: assert property (watchdog_timeout |=> status.watchdog_expired_flag)
    else $error("timeout not recorded");
  cover property ($rose(clock_stop));
  cover property ($fell(clock_stop));
  cover property ($fell(status.watchdog_expired_flag));
endmodule
bind mie_core mie_core_chk mie_core_chk_i (.clk_sys, .reset, .dmem_we, .wake_pin,
  .watchdog_timeout, .watchdog_counter_clear, .clock_stop, .acc, .prog_addr, .status);

// ### sim/mie_core_tb.sv
// Purpose: self-checking bench of the execution core
// Assumes: instruction at address k-1 executes at edge k after reset
// Notes: interrupts are left idle except for one entry at the end of the branch test
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module mie_core_tb;
  logic clk_sys, reset, dmem_we, irq_pending, watchdog_timeout, wake_pin;
  logic watchdog_counter_clear, clock_stop, master_irq_enable;
  logic [9:0] prog_addr;
  logic [15:0] prog_data;
  logic [6:0] dmem_addr;
  logic [7:0] dmem_rdata, dmem_wdata, table_pointer, acc, lookup_high_byte;
  mie_pkg::mie_flags_s status;
  int mismatches = 0;
  int n_compared = 0;
  mie_core mie_core_i (.clk_sys, .reset, .prog_addr, .prog_data, .dmem_addr, .dmem_rdata,
    .dmem_wdata, .dmem_we, .table_pointer, .irq_pending, .watchdog_timeout, .wake_pin,
    .watchdog_counter_clear, .clock_stop, .master_irq_enable, .acc, .lookup_high_byte, .status);
  mie_mem mie_mem_i (.clk_sys, .prog_addr, .prog_data, .dmem_addr, .dmem_rdata,
    .dmem_wdata, .dmem_we);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] w(mie_pkg::mie_op_e op, logic [9:0] arg);
    return {op, arg};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Memories are cleared under reset so every test starts from NOPs
  task automatic boot();
    reset = 1'b1;
    foreach (mie_mem_i.rom[k]) mie_mem_i.rom[k] = 16'h0000;
    foreach (mie_mem_i.ram[k]) mie_mem_i.ram[k] = 8'h00;
    cyc(3);
    reset = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_alu();
    boot();
    mie_mem_i.rom[0] = w(mie_pkg::OP_LOAD_IMM, 10'h08f);
    mie_mem_i.rom[1] = w(mie_pkg::OP_ADD_IMM, 10'h081);
    mie_mem_i.rom[2] = w(mie_pkg::OP_ADC_MEM, 10'h005);
    mie_mem_i.rom[3] = w(mie_pkg::OP_LOAD_IMM, 10'h03c);
    mie_mem_i.rom[4] = w(mie_pkg::OP_AND_INTO_MEM, 10'h007);
    mie_mem_i.ram[5] = 8'hef;
    mie_mem_i.ram[7] = 8'h5a;
    cyc(2);
    `CHK("add acc", 8'h10, acc)
    `CHK("add flags", 6'h0b, status)
    cyc(1);
    `CHK("adc acc", 8'h00, acc)
    `CHK("adc flags", 6'h07, status)
    cyc(2);
    `CHK("and mem", 8'h18, mie_mem_i.ram[7])
    `CHK("and flags", 6'h03, status)
    `CHK("move acc", 8'h3c, acc)
    $display("Test alu done");
  endtask
  // Call, taken skip, interrupt return, untaken skip, then an interrupt entry
  task automatic t_branch();
    boot();
    mie_mem_i.rom[0] = w(mie_pkg::OP_CALL, 10'h020);
    mie_mem_i.rom[1] = w(mie_pkg::OP_SKIP_BIT_NONZERO, 10'h005);
    mie_mem_i.rom[32] = w(mie_pkg::OP_SKIP_ZERO, 10'h005);
    mie_mem_i.rom[33] = w(mie_pkg::OP_LOAD_IMM, 10'h055);
    mie_mem_i.rom[34] = w(mie_pkg::OP_IRQ_RETURN, 10'h000);
    cyc(3);
    `CHK("skip pc", 10'h022, prog_addr)
    cyc(2);
    `CHK("return pc", 10'h001, prog_addr)
    `CHK("irq enable", 1'b1, master_irq_enable)
    cyc(2);
    `CHK("no skip pc", 10'h002, prog_addr)
    `CHK("skipped acc", 8'h00, acc)
    `CHK("branch flags", 6'h00, status)
    irq_pending = 1'b1;
    cyc(1);
    `CHK("irq entry pc", 10'h004, prog_addr)
    irq_pending = 1'b0;
    $display("Test branch done");
  endtask
  task automatic t_bits();
    boot();
    mie_mem_i.rom[0] = w(mie_pkg::OP_BIT_CLR, 10'h185);
    mie_mem_i.rom[1] = w(mie_pkg::OP_BYTE_SET, 10'h007);
    mie_mem_i.rom[2] = w(mie_pkg::OP_BYTE_CLR, 10'h008);
    mie_mem_i.rom[3] = w(mie_pkg::OP_TABLE_LAST, 10'h009);
    mie_mem_i.rom[4] = w(mie_pkg::OP_NIBBLE_SWAP_ACC, 10'h009);
    mie_mem_i.rom[5] = w(mie_pkg::OP_INC_SKIP, 10'h007);
    mie_mem_i.rom[6] = w(mie_pkg::OP_LOAD_IMM, 10'h011);
    mie_mem_i.rom[7] = w(mie_pkg::OP_STORE_ACC, 10'h006);
    mie_mem_i.rom[786] = 16'hbeef;
    mie_mem_i.ram[5] = 8'hff;
    mie_mem_i.ram[8] = 8'haa;
    cyc(5);
    `CHK("bit clear", 8'hf7, mie_mem_i.ram[5])
    `CHK("byte set", 8'hff, mie_mem_i.ram[7])
    `CHK("byte clear", 8'h00, mie_mem_i.ram[8])
    `CHK("table low", 8'hef, mie_mem_i.ram[9])
    `CHK("table high", 8'hbe, lookup_high_byte)
    `CHK("table pc", 10'h004, prog_addr)
    `CHK("bit flags", 6'h00, status)
    cyc(5);
    `CHK("swap acc", 8'hfe, acc)
    `CHK("inc skip", 8'h00, mie_mem_i.ram[7])
    `CHK("pcl pc", 10'h0fe, prog_addr)
    $display("Test bits done");
  endtask
  // Repeated pre-clear, real pair, single clear, then sleep and wake
  task automatic t_wdt();
    int k;
    boot();
    mie_mem_i.rom[2] = w(mie_pkg::OP_WDT_PRE_A, 10'h000);
    mie_mem_i.rom[3] = w(mie_pkg::OP_WDT_PRE_A, 10'h000);
    mie_mem_i.rom[4] = w(mie_pkg::OP_WDT_PRE_B, 10'h000);
    mie_mem_i.rom[6] = w(mie_pkg::OP_WDT_CLEAR, 10'h000);
    mie_mem_i.rom[7] = w(mie_pkg::OP_HALT, 10'h000);
    mie_mem_i.rom[8] = w(mie_pkg::OP_LOAD_IMM, 10'h03c);
    cyc(1);
    watchdog_timeout = 1'b1;
    cyc(1);
    watchdog_timeout = 1'b0;
    cyc(2);
    `CHK("repeat pre", 1'b1, status.watchdog_expired_flag)
    cyc(1);
    `CHK("pair clear", 1'b0, status.watchdog_expired_flag)
    `CHK("pair pulse", 1'b1, watchdog_counter_clear)
    watchdog_timeout = 1'b1;
    cyc(1);
    watchdog_timeout = 1'b0;
    cyc(1);
    `CHK("wdt clear", 1'b0, status.watchdog_expired_flag)
    cyc(1);
    `CHK("sleep flag", 1'b1, status.sleep_entered_flag)
    cyc(4);
    `CHK("asleep", 1'b1, clock_stop)
    `CHK("sleep pc", 10'h008, prog_addr)
    wake_pin = 1'b1;
    for (k = 0; k < 10 && clock_stop !== 1'b0; k++) cyc(1);
    `CHK("woke", 1'b0, clock_stop)
    wake_pin = 1'b0;
    cyc(2);
    `CHK("resume acc", 8'h3c, acc)
    $display("Test watchdog done");
  endtask
  // ==========================================================
  // Clock and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    reset = 1'b1;
    irq_pending = 1'b0;
    watchdog_timeout = 1'b0;
    wake_pin = 1'b0;
    table_pointer = 8'h12;
    t_alu();
    t_branch();
    t_bits();
    t_wdt();
    tally_and_finish();
  end
endmodule

// ### sim/mie_mem.sv
// Purpose: program and data memory facing the core
// Assumes: reads answer in the same cycle
// Notes: the bench preloads both arrays directly
`timescale 1ns/10ps
module mie_mem (
  input logic clk_sys,
  input logic [mie_pkg::MIE_PC_W-1:0] prog_addr,
  output logic [mie_pkg::MIE_WORD_W-1:0] prog_data,
  input logic [mie_pkg::MIE_MADDR_W-1:0] dmem_addr,
  output logic [mie_pkg::MIE_DATA_W-1:0] dmem_rdata,
  input logic [mie_pkg::MIE_DATA_W-1:0] dmem_wdata,
  input logic dmem_we
);
  logic [15:0] rom [1024];
  logic [7:0] ram [128];
  // Combinational reads, as the core samples them in the same cycle
  assign prog_data = rom[prog_addr];
  assign dmem_rdata = ram[dmem_addr];
  // Writes land on the rising edge
  always @(posedge clk_sys)
    if (dmem_we) ram[dmem_addr] <= dmem_wdata;
endmodule
